// *** sleep_pkg.sv ***
// constants and types for the sleep and brown-out sequencer
// Notes on behaviour
// - a supply at or below the brown-out threshold holds the chip in reset until it rises above it and the power-on count has run out.
// - the deep-sleep opcode stops the internal clock and halts the resonator oscillator.
// - any enabled interrupt from sources three to five, or a host USB reset, ends deep sleep.
// - timers get no clock in deep sleep, so a timer interrupt cannot wake from it.
// - a wake by interrupt branches to that interrupt's vector and the program resumes after it.
// - opcode 6f enters deep sleep and 7f enters light sleep, normally after ff.
// - pending interrupts are served in fixed order, source zero first, source five last.
// - light sleep gates only the cpu clock; timers and all six interrupts stay live and wake it.
// - a host USB reset resets the chip even in deep sleep and is recorded as the reset cause.
// - the power-on delay is skipped when recovering from deep sleep.
`default_nettype none
package sleep_pkg;
	localparam logic [7:0] OP_NOP        = 8'hff;
	localparam logic [7:0] OP_DEEP_SLEEP = 8'h6f;
	localparam logic [7:0] OP_LIGHT_SLEEP = 8'h7f;
	localparam int         NUM_IRQ       = 6;
	localparam int         TIMER_IRQ_MASK = 6'h07;
	localparam longint     CLK_HZ        = 10000000;
	localparam longint     POR_TIME_MS   = 98;
	localparam longint     POR_CYCLES    = (POR_TIME_MS * CLK_HZ) / 1000;
	localparam logic [1:0] CAUSE_POWER   = 2'h0;
	localparam logic [1:0] CAUSE_BROWNOUT = 2'h1;
	localparam logic [1:0] CAUSE_USB     = 2'h2;
	typedef enum logic [2:0] {ST_POR, ST_RUN, ST_DEEP, ST_LIGHT, ST_VECTOR} mode_t;
endpackage
`default_nettype wire

// *** sleep_and_brownout_control.sv ***
// power-mode and supply-fault sequencer
`default_nettype none
module sleep_and_brownout_control import sleep_pkg::*; #(
	parameter int POR_COUNT = int'(POR_CYCLES)
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	// supply and host
	input  wire logic       brownout_threshold,
	input  wire logic       usb_reset,
	// cpu instruction stream
	input  wire logic       op_valid,
	input  wire logic [7:0] op_code,
	input  wire logic       isr_return,
	// interrupt sources
	input  wire logic [5:0] irq_pending,
	input  wire logic [5:0] irq_enable,
	// outputs
	output logic            chip_reset,
	output logic            cpu_clk_en,
	output logic            osc_en,
	output logic            timer_clk_en,
	output logic            vector_valid,
	output logic [2:0]      vector_id,
	output logic [1:0]      reset_cause,
	output logic            deep_sleep_recovery
);
	mode_t        mode_q;
	logic [31:0]  por_cnt_q;
	logic [5:0]   live;
	logic [2:0]   pri;
	logic         any_live;
	logic         deep_op;
	logic         light_op;
	logic         supply_fault;

	// executed sleep opcodes; a code without op_valid counts for nothing
	assign deep_op      = op_valid && (op_code == OP_DEEP_SLEEP);
	assign light_op     = op_valid && (op_code == OP_LIGHT_SLEEP);
	// brown-out and host reset share one path into the power-on sequence
	assign supply_fault = brownout_threshold || usb_reset;

	// timers are dead in deep sleep, so their requests are masked there
	always_comb begin
		live = irq_pending & irq_enable;
		if (mode_q == ST_DEEP)
			live = live & ~TIMER_IRQ_MASK[5:0];
		any_live = |live;
		pri = 3'h0;
		for (int i = NUM_IRQ - 1; i >= 0; i--) begin
			if (live[i])
				pri = i[2:0];
		end
	end

	// main mode sequencer; brown-out and usb reset override everything
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mode_q    <= ST_POR;
			por_cnt_q <= 32'h0;
		end else if (brownout_threshold || usb_reset) begin
			mode_q    <= ST_POR;
			por_cnt_q <= 32'h0;
		end else begin
			case (mode_q)
				ST_POR: begin
					if (por_cnt_q >= 32'(POR_COUNT - 1))
						mode_q <= ST_RUN;
					else
						por_cnt_q <= por_cnt_q + 32'h1;
				end
				ST_RUN: begin
					if (deep_op)
						mode_q <= ST_DEEP;
					else if (light_op)
						mode_q <= ST_LIGHT;
				end
				ST_DEEP: begin
					if (any_live)
						mode_q <= ST_VECTOR;
				end
				ST_LIGHT: begin
					if (any_live)
						mode_q <= ST_VECTOR;
				end
				ST_VECTOR: begin
					if (isr_return)
						mode_q <= ST_RUN;
				end
				default: mode_q <= ST_POR;
			endcase
		end
	end

	// registered outputs; reset asserted in the power-on window
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			chip_reset   <= 1'b1;
			cpu_clk_en   <= 1'b0;
			osc_en       <= 1'b1;
			timer_clk_en <= 1'b0;
		end else begin
			chip_reset   <= brownout_threshold || usb_reset || (mode_q == ST_POR);
			cpu_clk_en   <= (mode_q == ST_RUN || mode_q == ST_VECTOR);
			osc_en       <= (mode_q != ST_DEEP);
			timer_clk_en <= (mode_q != ST_DEEP && mode_q != ST_POR);
		end
	end

	// vector capture at wake, held until the service routine returns
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			vector_valid <= 1'b0;
			vector_id    <= 3'h0;
		end else if (brownout_threshold || usb_reset) begin
			vector_valid <= 1'b0;
		end else if ((mode_q == ST_DEEP || mode_q == ST_LIGHT) && any_live) begin
			vector_valid <= 1'b1;
			vector_id    <= pri;
		end else if (mode_q == ST_VECTOR && isr_return) begin
			vector_valid <= 1'b0;
		end
	end

	// reset cause and recovery flag for firmware to inspect
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reset_cause         <= CAUSE_POWER;
			deep_sleep_recovery <= 1'b0;
		end else begin
			if (usb_reset)
				reset_cause <= CAUSE_USB;
			else if (brownout_threshold)
				reset_cause <= CAUSE_BROWNOUT;
			if (mode_q == ST_DEEP && any_live && !usb_reset && !brownout_threshold)
				deep_sleep_recovery <= 1'b1;
			else if (mode_q == ST_RUN && deep_op)
				deep_sleep_recovery <= 1'b0;
		end
	end

	// checks on the mode sequencer, clock gates and reset outputs
	AST_BO_RESET: assert property (@(posedge ref_clk) disable iff (sys_rst)
		brownout_threshold |=> chip_reset)
		else $error("brown-out did not hold reset");
	AST_DEEP_OSC: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == ST_DEEP) |=> !osc_en && !cpu_clk_en)
		else $error("oscillator ran in deep sleep");
	AST_WAKE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == ST_DEEP && any_live && !usb_reset && !brownout_threshold)
		|=> mode_q == ST_VECTOR)
		else $error("deep sleep missed wake");
	AST_TIMER_DEAD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == ST_DEEP) |=> !timer_clk_en)
		else $error("timer clocked in deep sleep");
	AST_VECTOR: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == ST_VECTOR && isr_return && !usb_reset && !brownout_threshold)
		|=> mode_q == ST_RUN ##1 !vector_valid)
		else $error("no return after service");
	AST_OPCODE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == ST_RUN && op_valid && op_code == OP_LIGHT_SLEEP && !usb_reset
		&& !brownout_threshold) |=> mode_q == ST_LIGHT ##1 !cpu_clk_en && osc_en)
		else $error("light sleep not entered");
	AST_PRIORITY: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == ST_LIGHT && live[0] && !usb_reset && !brownout_threshold)
		|=> vector_id == 3'h0)
		else $error("priority order broken");
	AST_USB_CAUSE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		usb_reset |=> reset_cause == CAUSE_USB && chip_reset)
		else $error("usb reset not recorded");
	AST_NO_POR: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == ST_DEEP && any_live && !usb_reset && !brownout_threshold)
		|=> mode_q == ST_VECTOR && !chip_reset)
		else $error("power-on delay after wake");
	AST_BO_SEQ: assert property (@(posedge ref_clk) disable iff (sys_rst)
		brownout_threshold |=> mode_q == ST_POR)
		else $error("brown-out not into power-on sequence");

	// light sleep keeps oscillator and timers alive, only the cpu clock stops
	AST_LIGHT_CLOCKS: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == ST_LIGHT)
		|=> !cpu_clk_en && osc_en && timer_clk_en)
		else $error("light sleep gated the wrong clocks");
	AST_LIGHT_WAKE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == ST_LIGHT && any_live && !supply_fault)
		|=> mode_q == ST_VECTOR && vector_valid)
		else $error("light sleep missed wake");
	// a timer request alone must leave deep sleep untouched
	AST_DEEP_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == ST_DEEP && !any_live && !supply_fault)
		|=> mode_q == ST_DEEP && !vector_valid)
		else $error("deep sleep left without enabled wake");
	AST_USB_DEEP: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == ST_DEEP && usb_reset)
		|=> mode_q == ST_POR && chip_reset)
		else $error("usb reset ignored in deep sleep");
	AST_CAUSE_BO: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(brownout_threshold && !usb_reset)
		|=> reset_cause == CAUSE_BROWNOUT)
		else $error("brown-out not recorded");
	// anything but an executed sleep opcode or a supply fault leaves run mode alone
	AST_IDLE_RUN: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == ST_RUN && !deep_op && !light_op && !supply_fault)
		|=> mode_q == ST_RUN)
		else $error("run mode left without sleep opcode");
	AST_DSR_CLEAR: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == ST_RUN && deep_op && !supply_fault)
		|=> mode_q == ST_DEEP && !deep_sleep_recovery)
		else $error("recovery flag kept over deep sleep entry");
	AST_VECTOR_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == ST_VECTOR && !isr_return && !supply_fault)
		|=> mode_q == ST_VECTOR && vector_valid && $stable(vector_id))
		else $error("vector dropped before return");
	// the power-on count restarts from zero once the supply recovers
	AST_BO_RELEASE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$fell(brownout_threshold)
		|-> mode_q == ST_POR && por_cnt_q == 32'h0)
		else $error("brown-out release skipped the power-on count");
	AST_POR_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(mode_q == ST_POR)
		|=> chip_reset)
		else $error("reset released inside the power-on count");
endmodule
`default_nettype wire

// *** cpu_model.sv ***
// processor core model issuing sleep opcodes
`default_nettype none
module cpu_model import sleep_pkg::*; (
	// clock and command
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       go,
	input  wire logic       deep,
	// executed opcode stream
	output logic            op_valid,
	output logic [7:0]      op_code
);
	logic nop_q;
	// no-op first to flush the pipeline, then the sleep opcode
	// idle code steps through every byte, sleep codes included, with valid low
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			nop_q    <= 1'b0;
			op_valid <= 1'b0;
			op_code  <= OP_NOP;
		end else begin
			nop_q    <= go;
			op_valid <= go | nop_q;
			op_code  <= go ? OP_NOP : nop_q ? (deep ? OP_DEEP_SLEEP : OP_LIGHT_SLEEP)
				: op_code + 8'h25;
		end
	end
endmodule
`default_nettype wire

// *** sleep_and_brownout_control_bench.sv ***
// self-checking bench for the sleep and brown-out sequencer
`default_nettype none
module sleep_and_brownout_control_bench import sleep_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, sys_rst, bo, usb, go, deep, ret, ov, rst_o, cpu, osc, tmr, vv, dsr;
	logic [7:0] op;
	logic [5:0] pend, en, r;
	logic [2:0] vid;
	logic [1:0] rc;
	int err_total, checks, seed, cyc_n = 0;
	initial begin
		ref_clk = 0;
		forever #50 ref_clk = ~ref_clk;
	end
	// hang guard, far above the roughly 175 cycles needed
	always @(posedge ref_clk) begin
		cyc_n++;
		if (cyc_n == 3000) begin
			err_total++;
			complete_run();
		end
	end
	sleep_and_brownout_control #(.POR_COUNT(8)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.brownout_threshold(bo), .usb_reset(usb), .op_valid(ov), .op_code(op),
		.isr_return(ret), .irq_pending(pend), .irq_enable(en), .chip_reset(rst_o),
		.cpu_clk_en(cpu), .osc_en(osc), .timer_clk_en(tmr), .vector_valid(vv),
		.vector_id(vid), .reset_cause(rc), .deep_sleep_recovery(dsr));
	cpu_model i_cpu (.ref_clk(ref_clk), .rst(sys_rst), .go(go), .deep(deep),
		.op_valid(ov), .op_code(op));
	function automatic logic [2:0] first(input logic [5:0] v);
		first = 3'h0;
		for (int i = 5; i >= 0; i--) if (v[i]) first = 3'(i);
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wait_run();
		for (int i = 0; i < 30 && rst_o !== 1'b0; i++) cyc(1);
		chk(rst_o, 0);
	endtask
	task automatic sleep(input logic d);
		go <= 1;
		deep <= d;
		cyc(1);
		go <= 0;
		cyc(4);
	endtask
	// wake, check vector, then return from the service routine
	task automatic wake(input logic [5:0] m);
		r = 6'($random(seed));
		r[5] = 1'b1;
		pend <= r;
		cyc(3);
		chk(vv, 1);
		chk(vid, first(r & m));
		pend <= 0;
		ret <= 1;
		cyc(1);
		ret <= 0;
		cyc(3);
		chk({vv, cpu}, 1);
	endtask
	initial begin
		seed    = 69;
		sys_rst = 1'b1;
		{bo, usb, go, deep, ret} = 5'h00;
		pend    = 6'h00;
		en      = 6'h3f;
		cyc(12);
		sys_rst <= 0;
		wait_run();
		chk(rc, CAUSE_POWER);
		repeat (3) begin
			sleep(1);
			chk({osc, cpu, tmr, dsr}, 0);
			// a light-sleep opcode inside deep sleep is refused
			sleep(0);
			chk({osc, cpu, tmr}, 0);
			en <= 6'h1f;
			pend <= 6'h27;
			cyc(4);
			chk(vv, 0);
			en <= 6'h3f;
			wake(6'h38);
			chk({dsr, rst_o}, 2);
		end
		repeat (3) begin
			sleep(0);
			chk({osc, tmr, cpu}, 6);
			wake(6'h3f);
		end
		bo <= 1;
		cyc(25);
		chk({rst_o, rc}, {1'b1, CAUSE_BROWNOUT});
		bo <= 0;
		wait_run();
		sleep(1);
		usb <= 1;
		cyc(3);
		chk({rst_o, rc}, {1'b1, CAUSE_USB});
		usb <= 0;
		wait_run();
		complete_run();
	end
endmodule
`default_nettype wire
